// [logic/cltz_pkg.sv]
// Package: register map, field layouts and constants of the limit regs
package cltz_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ILIM = 8'h01;
  localparam logic [7:0] ADDR_FLOAT = 8'h02;
  localparam logic [7:0] ADDR_ICHG = 8'h04;
  localparam logic [7:0] ADDR_VFLOOR = 8'h05;
  localparam logic [7:0] ADDR_SAFETY = 8'h06;
  localparam logic [7:0] ADDR_ZONE = 8'h12;
  // ---------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------
  typedef struct packed {logic [1:0] code; logic [5:0] rest;} cltz_ilim_s;
  typedef struct packed {logic [5:0] code; logic [1:0] rest;} cltz_float_s;
  typedef struct packed {logic [3:0] code; logic [3:0] rest;} cltz_ichg_s;
  typedef struct packed {
    logic [3:0] rest;
    logic limiting;
    logic [2:0] code;
  } cltz_vfloor_s;
  typedef struct packed {logic [3:0] ic; logic [3:0] fv;} cltz_safety_s;
  typedef struct packed {
    logic temperature_control_disable;
    logic [1:0] rsvd;
    logic valid;
    logic [3:0] zone;
  } cltz_zone_s;
  // Synchronised analog comparator and strap inputs
  typedef struct packed {
    logic strap;
    logic at_floor;
    logic lim_reached;
    logic pgood;
    logic batt_low;
    logic above_short;
    logic sw_active;
    logic [3:0] zone;
    logic grounded;
  } cltz_pins_s;
  typedef enum logic [1:0] {
    LOOP_IDLE, LOOP_RAISE, LOOP_HOLD, LOOP_LIMIT
  } cltz_loop_e;
  // ---------------------------------------------------------------
  // Reset values (plain defaults)
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_SAFETY = 8'h00;
  // ---------------------------------------------------------------
  // Codes and scales
  // ---------------------------------------------------------------
  localparam logic [3:0] ZONE_HOT = 4'hF;
  localparam logic [3:0] ZONE_WARM = 4'h7;
  localparam logic [3:0] ZONE_COOL = 4'h1;
  localparam logic [3:0] ZONE_COLD = 4'h0;
  localparam logic [1:0] ILIM_NONE = 2'h3;
  localparam logic [12:0] FLOOR_BASE_MV = 13'd4213;
  localparam logic [12:0] FLOOR_STEP_MV = 13'd80;
  localparam logic [10:0] ICEIL_BASE_MA = 11'd550;
  localparam logic [10:0] ICEIL_STEP_MA = 11'd100;
  localparam logic [10:0] ICEIL_TOP_MA = 11'd1550;
  localparam logic [3:0] ICEIL_MAX_CODE = 4'h9;
  localparam logic [5:0] FV_CEIL_BASE = 6'h23;
  localparam logic [3:0] FV_CEIL_CAP = 4'hC;
  localparam logic [5:0] FV_COOL_CODE = 6'h19;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int ZONE_PERIOD_NS = 1000000000;
  localparam int ZONE_PERIOD_CYC = ZONE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LOOP_STEP_NS = 1000;
  localparam int LOOP_STEP_CYC = LOOP_STEP_NS / CLK_PERIOD_NS;
endpackage

// [logic/cltz_regs.sv]
// Module: charger limit, safety ceiling and thermal zone registers
`timescale 1ns/1ps
module cltz_regs
  import cltz_pkg::*;
#(
  parameter int ZONE_CYC = ZONE_PERIOD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire cltz_pins_s pins_i,
  output logic charge_allowed_o,
  output logic [1:0] input_current_limit_code_o,
  output logic input_limit_off_o,
  output logic [2:0] input_voltage_floor_code_o,
  output logic [12:0] input_floor_mv_o,
  output logic [5:0] float_voltage_setting_o,
  output logic [3:0] charge_current_setting_o,
  output logic [10:0] current_ceiling_ma_o,
  output logic charge_half_o,
  output logic charge_inhibit_o,
  output logic [3:0] charge_level_o,
  output logic input_voltage_limiting_flag_o,
  output logic thermistor_valid_flag_o,
  output logic [3:0] thermal_zone_bits_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    cltz_pins_s sync1;
    cltz_pins_s sync2;
    logic sw_prev;
    logic auto_var;
    logic host_go;
    logic locked;
    logic pend_v;
    logic [7:0] pend;
    cltz_safety_s safety;
    cltz_ilim_s ilim;
    cltz_float_s fv;
    cltz_ichg_s ic;
    cltz_vfloor_s vf;
    cltz_zone_s zn;
    logic [26:0] ztimer;
    logic [7:0] ltimer;
    logic [3:0] level;
    cltz_loop_e loop;
    logic [7:0] rdata;
  } cltz_state_s;

  localparam logic [26:0] ZONE_LAST = 27'(ZONE_CYC - 1);
  localparam logic [7:0] LOOP_LAST = 8'(LOOP_STEP_CYC - 1);

  cltz_state_s s_reg;
  cltz_state_s s_next;
  logic [5:0] fv_max;
  logic [3:0] zone_step;
  logic zone_adj;
  logic [3:0] target;
  logic wr_safety;
  logic wr_other;

  // ---------------------------------------------------------------
  // Decoded ceilings and settings
  // ---------------------------------------------------------------
  // Float ceiling saturates at step 12 whatever the code
  assign zone_step = (s_reg.safety.fv > FV_CEIL_CAP) ? FV_CEIL_CAP
                                                     : s_reg.safety.fv;
  assign fv_max = FV_CEIL_BASE + {2'h0, zone_step};
  assign current_ceiling_ma_o = (s_reg.safety.ic > ICEIL_MAX_CODE) ?
      ICEIL_TOP_MA :
      ICEIL_BASE_MA + 11'(s_reg.safety.ic) * ICEIL_STEP_MA;
  assign input_floor_mv_o = FLOOR_BASE_MV +
      13'(s_reg.vf.code) * FLOOR_STEP_MV;
  assign input_voltage_floor_code_o = s_reg.vf.code;
  assign input_current_limit_code_o = s_reg.ilim.code;
  assign input_limit_off_o = (s_reg.ilim.code == ILIM_NONE);

  // Zone effects apply only with a valid reading and control enabled
  assign zone_adj = s_reg.zn.valid && !s_reg.zn.temperature_control_disable;
  assign charge_inhibit_o = zone_adj &&
      (s_reg.zn.zone == ZONE_COLD || s_reg.zn.zone == ZONE_HOT);
  assign charge_half_o = zone_adj &&
      (s_reg.zn.zone == ZONE_COOL || s_reg.zn.zone == ZONE_WARM);
  // Clamp again at the output: a later ceiling commit may be lower
  assign float_voltage_setting_o = charge_half_o ? FV_COOL_CODE :
      (s_reg.fv.code > fv_max) ? fv_max : s_reg.fv.code;
  assign charge_current_setting_o =
      (s_reg.ic.code > s_reg.safety.ic) ? s_reg.safety.ic
                                        : s_reg.ic.code;
  assign target = charge_half_o ? {1'b0, charge_current_setting_o[3:1]}
                                : charge_current_setting_o;
  // No-auto variant holds off until the host has spoken
  assign charge_allowed_o = s_reg.sync2.pgood && !charge_inhibit_o &&
      (s_reg.auto_var || s_reg.host_go);
  assign charge_level_o = s_reg.level;
  assign input_voltage_limiting_flag_o = s_reg.vf.limiting;
  assign thermistor_valid_flag_o = s_reg.zn.valid;
  assign thermal_zone_bits_o = s_reg.zn.zone;
  assign reg_rdata_o = s_reg.rdata;
  assign wr_safety = reg_wr_i && reg_addr_i == ADDR_SAFETY;
  assign wr_other = reg_wr_i && (reg_addr_i == ADDR_ILIM ||
      reg_addr_i == ADDR_FLOAT || reg_addr_i == ADDR_ICHG ||
      reg_addr_i == ADDR_VFLOOR || reg_addr_i == ADDR_ZONE);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.sync1 = pins_i;
    s_next.sync2 = s_reg.sync1;
    s_next.sw_prev = s_reg.sync2.sw_active;
    // Static strap; only the second stage is read, never the first
    s_next.auto_var = s_reg.sync2.strap;

    // Host writes; over-ceiling codes are stored as the ceiling
    if (wr_other) begin
      s_next.host_go = 1'b1;
      s_next.locked = 1'b1;
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_ILIM: s_next.ilim = cltz_ilim_s'(reg_wdata_i);
        ADDR_FLOAT: begin
          s_next.fv = cltz_float_s'(reg_wdata_i);
          if (reg_wdata_i[7:2] > fv_max) begin
            s_next.fv.code = fv_max;
          end
        end
        ADDR_ICHG: begin
          s_next.ic = cltz_ichg_s'(reg_wdata_i);
          if (reg_wdata_i[7:4] > s_reg.safety.ic) begin
            s_next.ic.code = s_reg.safety.ic;
          end
        end
        ADDR_VFLOOR: begin
          s_next.vf.rest = reg_wdata_i[7:4];
          s_next.vf.code = reg_wdata_i[2:0];
        end
        ADDR_ZONE: s_next.zn.temperature_control_disable = reg_wdata_i[7];
        ADDR_SAFETY: begin
          // Pair compare while unlocked: a match commits, anything else re-arms
          if (!s_reg.locked) begin
            if (s_reg.pend_v && s_reg.pend == reg_wdata_i) begin
              s_next.safety = cltz_safety_s'(reg_wdata_i);
              s_next.pend_v = 1'b0;
            end else begin
              s_next.pend = reg_wdata_i;
              s_next.pend_v = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    // Any other mapped-register write between the pair breaks it
    if (wr_other) begin
      s_next.pend_v = 1'b0;
    end

    // Read port, one cycle latency, unmapped reads zero
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_ILIM: s_next.rdata = s_reg.ilim;
        ADDR_FLOAT: s_next.rdata = s_reg.fv;
        ADDR_ICHG: s_next.rdata = s_reg.ic;
        ADDR_VFLOOR: s_next.rdata = s_reg.vf;
        ADDR_SAFETY: s_next.rdata = s_reg.safety;
        ADDR_ZONE: s_next.rdata = {s_reg.zn.temperature_control_disable, 2'h0,
                                   s_reg.zn.valid, s_reg.zn.zone};
        default: s_next.rdata = 8'h00;
      endcase
    end

    // Thermistor sampling on entry to switching, then per second
    if (s_reg.sync2.sw_active) begin
      s_next.ztimer = (s_reg.ztimer == ZONE_LAST) ? 27'h0
                                                  : s_reg.ztimer + 27'h1;
    end
    if (s_reg.sync2.sw_active && !s_reg.sw_prev) begin
      s_next.zn.zone = s_reg.sync2.zone;
      s_next.zn.valid = 1'b1;
      s_next.ztimer = 27'h0;
    end else if (s_reg.sync2.sw_active && s_reg.ztimer == ZONE_LAST) begin
      s_next.zn.zone = s_reg.sync2.zone;
      s_next.zn.valid = 1'b1;
    end
    // Grounded input overrides any reading
    if (s_reg.sync2.grounded) begin
      s_next.zn.zone = ZONE_COLD;
      s_next.zn.valid = 1'b0;
    end

    // Input-voltage loop, one step per loop period
    s_next.ltimer = (s_reg.ltimer == LOOP_LAST) ? 8'h0
                                                : s_reg.ltimer + 8'h1;
    if (s_reg.ltimer == LOOP_LAST) begin
      case (s_reg.loop)
        LOOP_IDLE, LOOP_RAISE, LOOP_HOLD, LOOP_LIMIT: begin
          if (!charge_allowed_o) begin
            s_next.level = 4'h0;
            s_next.loop = LOOP_IDLE;
          end else if (s_reg.sync2.at_floor) begin
            if (s_reg.level != 4'h0) begin
              s_next.level = s_reg.level - 4'h1;
            end
            s_next.loop = LOOP_LIMIT;
          end else if (s_reg.level > target) begin
            s_next.level = s_reg.level - 4'h1;
            s_next.loop = LOOP_HOLD;
          end else if (s_reg.sync2.lim_reached || s_reg.level == target) begin
            s_next.loop = LOOP_HOLD;
          end else begin
            s_next.level = s_reg.level + 4'h1;
            s_next.loop = LOOP_RAISE;
          end
        end
        default: s_next.loop = LOOP_IDLE;
      endcase
    end
    s_next.vf.limiting = (s_next.loop == LOOP_LIMIT);

    // Low battery resets the control registers, and the disable bit
    if (s_reg.sync2.batt_low) begin
      s_next.ilim = cltz_ilim_s'(RST_REG);
      s_next.fv = cltz_float_s'(RST_REG);
      s_next.ic = cltz_ichg_s'(RST_REG);
      s_next.vf.rest = 4'h0;
      s_next.vf.code = 3'h0;
      s_next.zn.temperature_control_disable = 1'b0;
      s_next.host_go = 1'b0;
    end
    // Below short threshold the ceiling holds default and unlocks
    if (!s_reg.sync2.above_short) begin
      s_next.safety = cltz_safety_s'(RST_SAFETY);
      s_next.locked = 1'b0;
      s_next.pend_v = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.safety <= cltz_safety_s'(RST_SAFETY);
      s_reg.loop <= LOOP_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  localparam int LOOP_WAIT = 260;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_open_write;
    wr_safety && !s_reg.locked && s_reg.sync2.above_short;
  endsequence

  property p_disable_cleared;
    s_reg.sync2.batt_low |=> !s_reg.zn.temperature_control_disable;
  endproperty
  a_disable_cleared: assert property (p_disable_cleared)
    else $error("disable bit survived register reset");

  property p_disable_no_adjust;
    s_reg.zn.temperature_control_disable |-> !charge_half_o && !charge_inhibit_o;
  endproperty
  a_disable_no_adjust: assert property (p_disable_no_adjust)
    else $error("zone adjusted while disabled");

  property p_ground_clears;
    s_reg.sync2.grounded |=> !thermistor_valid_flag_o &&
                             thermal_zone_bits_o == ZONE_COLD;
  endproperty
  a_ground_clears: assert property (p_ground_clears)
    else $error("grounded thermistor left flags set");

  property p_entry_sample;
    s_reg.sync2.sw_active && !s_reg.sw_prev && !s_reg.sync2.grounded
      |=> thermal_zone_bits_o == $past(s_reg.sync2.zone);
  endproperty
  a_entry_sample: assert property (p_entry_sample)
    else $error("zone not sampled on switching entry");

  property p_float_capped;
    float_voltage_setting_o <= fv_max;
  endproperty
  a_float_capped: assert property (p_float_capped)
    else $error("float setting above ceiling");

  property p_store_ceiling;
    reg_wr_i && reg_addr_i == ADDR_ICHG && !s_reg.sync2.batt_low &&
      reg_wdata_i[7:4] > s_reg.safety.ic
      |=> s_reg.ic.code == $past(s_reg.safety.ic);
  endproperty
  a_store_ceiling: assert property (p_store_ceiling)
    else $error("over-ceiling current code stored");

  property p_locked_hold;
    wr_safety && s_reg.locked && s_reg.sync2.above_short
      |=> $stable(s_reg.safety);
  endproperty
  a_locked_hold: assert property (p_locked_hold)
    else $error("locked safety register changed");

  property p_pair_commit;
    (seq_open_write and (s_reg.pend_v && s_reg.pend == reg_wdata_i))
      |=> s_reg.safety == $past(reg_wdata_i);
  endproperty
  a_pair_commit: assert property (p_pair_commit)
    else $error("matching pair did not commit");

  property p_mismatch_keeps;
    (seq_open_write and !(s_reg.pend_v && s_reg.pend == reg_wdata_i))
      |=> $stable(s_reg.safety);
  endproperty
  a_mismatch_keeps: assert property (p_mismatch_keeps)
    else $error("unpaired write changed safety");

  property p_floor_flag;
    (charge_allowed_o && s_reg.sync2.at_floor)[*2]
      |-> ##[0:LOOP_WAIT] input_voltage_limiting_flag_o;
  endproperty
  a_floor_flag: assert property (p_floor_flag)
    else $error("limiting flag not raised at floor");

  property p_noauto_wait;
    !s_reg.auto_var && !s_reg.host_go |-> !charge_allowed_o;
  endproperty
  a_noauto_wait: assert property (p_noauto_wait)
    else $error("charging without host in no-auto variant");
endmodule // cltz_regs

// [bench/cltz_host.sv]
// Host model: register bus master for the limit and zone registers
`timescale 1ns/1ps
module cltz_host (
  input wire logic clk_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  // Idle bus at time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'hFF;
    reg_wdata_o = 8'h00;
  end

  // Held up to the taking edge; bus then inverted so stale data never helps
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask

  // Read data is registered: it stands after the read edge, taken next edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge clk_i);
    d = reg_rdata_i;
  endtask

  // Ceiling value only takes effect when sent twice in a row
  task automatic pair(input logic [7:0] d);
    wr(8'h06, d);
    wr(8'h06, d);
  endtask
endmodule // cltz_host

// [bench/tb_top.sv]
// Testbench: limit, safety ceiling and thermal zone registers
`timescale 1ns/1ps
module tb_top;
  import cltz_pkg::*;
  localparam int ZC = 50;
  logic clk_i, rst_i, wr, rd, chg_ok, lim_off, half, inhib, vflag, tvalid;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] lcode;
  logic [2:0] fcode;
  logic [12:0] floor_mv;
  logic [5:0] fv;
  logic [3:0] ic, lvl, zone;
  logic [10:0] ceil_ma;
  cltz_pins_s pins;
  logic [7:0] mdl [0:31];
  logic [7:0] pend, r;
  logic pend_v, locked;
  logic [31:0] lf;
  int n_fail, cmp_count, cyc;

  cltz_regs #(.ZONE_CYC(ZC)) i_cltz_regs (
    .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .pins_i(pins), .charge_allowed_o(chg_ok),
    .input_current_limit_code_o(lcode), .input_limit_off_o(lim_off),
    .input_voltage_floor_code_o(fcode), .input_floor_mv_o(floor_mv),
    .float_voltage_setting_o(fv), .charge_current_setting_o(ic),
    .current_ceiling_ma_o(ceil_ma), .charge_half_o(half),
    .charge_inhibit_o(inhib), .charge_level_o(lvl),
    .input_voltage_limiting_flag_o(vflag),
    .thermistor_valid_flag_o(tvalid), .thermal_zone_bits_o(zone));
  cltz_host i_cltz_host (
    .clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  // ---------------------------------------------------------------
  // Checking and reference model
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction

  task automatic cw(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Model first, then the real write; a locked ceiling ignores writes
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [5:0] fc;
    logic [3:0] cc;
    fc = (mdl[6][3:0] > 4'hB) ? 6'h2F : 6'h23 + 6'(mdl[6][3:0]);
    cc = mdl[6][7:4];
    if (a == 8'h06) begin
      if (!locked && pend_v && pend == d) begin
        mdl[6] = d;
        pend_v = 1'b0;
      end else if (!locked) begin
        pend = d;
        pend_v = 1'b1;
      end
    end else begin
      locked = 1'b1;
      pend_v = 1'b0;
      case (a)
        8'h01: mdl[1] = d;
        8'h02: mdl[2] = {(d[7:2] > fc) ? fc : d[7:2], d[1:0]};
        8'h04: mdl[4] = {(d[7:4] > cc) ? cc : d[7:4], d[3:0]};
        8'h05: mdl[5] = d & 8'hF7;
        8'h12: mdl[18][7] = d[7];
        default: ;
      endcase
    end
    i_cltz_host.wr(a, d);
  endtask

  task automatic rc(input logic [7:0] a);
    logic [7:0] got;
    i_cltz_host.rd(a, got);
    chk(16'(got), 16'(mdl[a[4:0]]));
  endtask

  // Fresh zone sample on a rising switching-charge state
  task automatic zs(input logic [3:0] z);
    pins.zone <= z;
    pins.sw_active <= 1'b0;
    cw(4);
    pins.sw_active <= 1'b1;
    cw(6);
    mdl[18][4:0] = {1'b1, z};
    chk(16'(zone), 16'(z));
    chk(16'(tvalid), 16'h1);
  endtask

  // ---------------------------------------------------------------
  // Clock, reset, timeout
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_fail++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    pins = '0;
    pins.pgood = 1'b1;
    pins.above_short = 1'b1;
    pins.zone = 4'h3;
    lf = 32'hF5D1;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    pend = 8'h00;
    pend_v = 1'b0;
    locked = 1'b0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    cw(6);
    rst_i <= 1'b0;
    cw(2);
    rc(8'h12);
    rc(8'h06);
    // Hot, warm, cool and cold zone codes, normal range last
    zs(4'hF);
    zs(4'h7);
    zs(4'h1);
    zs(4'h0);
    zs(4'h3);
    pins.zone <= 4'h7;
    cw(ZC + 10);
    chk(16'(zone), 16'h7);
    chk(16'(chg_ok), 16'h0);
    // Back to the normal range so later settings are not halved
    zs(4'h3);
    // Ceiling table, one committed pair per code
    for (int i = 0; i < 16; i++) begin
      w(8'h06, 8'(i * 17));
      w(8'h06, 8'(i * 17));
      cw(1);
      chk(16'(ceil_ma), 16'((i > 9) ? 1550 : 550 + 100 * i));
    end
    w(8'h06, 8'hA5);
    w(8'h06, 8'hA5);
    w(8'h06, 8'h33);
    w(8'h06, 8'h44);
    rc(8'h06);
    w(8'h02, 8'hFC);
    rc(8'h02);
    chk(16'(fv), 16'h28);
    w(8'h04, 8'hF3);
    rc(8'h04);
    chk(16'(ic), 16'hA);
    chk(16'(chg_ok), 16'h1);
    i_cltz_host.pair(8'h11);
    rc(8'h06);
    // Input limit and floor codes, random filler in other bits
    for (int c = 0; c < 4; c++) begin
      r = rnd();
      w(8'h01, {2'(c), r[5:0]});
      rc(8'h01);
      chk(16'(lcode), 16'(c));
      chk(16'(lim_off), 16'(c == 3));
    end
    for (int c = 0; c < 8; c++) begin
      r = rnd();
      w(8'h05, {r[4:0], 3'(c)});
      rc(8'h05);
      chk(16'(fcode), 16'(c));
      chk(16'(floor_mv), 16'(4213 + 80 * c));
    end
    // Cool zone halves, disable bit lifts it, cold zone inhibits
    pins.zone <= 4'h1;
    cw(ZC + 10);
    chk(16'(half), 16'h1);
    chk(16'(fv), 16'h19);
    mdl[18][4:0] = 5'h11;
    w(8'h12, 8'h80);
    rc(8'h12);
    chk(16'(half), 16'h0);
    chk(16'(fv), 16'h28);
    w(8'h12, 8'h00);
    zs(4'h0);
    chk(16'(inhib), 16'h1);
    zs(4'h3);
    chk(16'(chg_ok), 16'h1);
    // Grounded thermistor clears the status
    pins.grounded <= 1'b1;
    cw(5);
    chk(16'({tvalid, zone}), 16'h0);
    pins.grounded <= 1'b0;
    zs(4'h3);
    // Loop climbs to target, then backs off at the floor
    cw(2200);
    chk(16'(lvl), 16'hA);
    pins.at_floor <= 1'b1;
    cw(140);
    chk(16'(vflag), 16'h1);
    chk(16'(lvl < 4'hA), 16'h1);
    mdl[5][3] = 1'b1;
    rc(8'h05);
    pins.at_floor <= 1'b0;
    // Battery short reloads and unlocks the ceiling
    pins.above_short <= 1'b0;
    cw(5);
    mdl[6] = 8'h00;
    locked = 1'b0;
    pend_v = 1'b0;
    rc(8'h06);
    pins.above_short <= 1'b1;
    cw(5);
    w(8'h06, 8'h5A);
    w(8'h06, 8'h5A);
    rc(8'h06);
    // Register reset clears the disable bit and host settings
    w(8'h12, 8'h80);
    pins.batt_low <= 1'b1;
    cw(5);
    chk(16'(chg_ok), 16'h0);
    pins.batt_low <= 1'b0;
    mdl[18][7] = 1'b0;
    mdl[1] = 8'h00;
    rc(8'h12);
    rc(8'h01);
    // Auto variant strap allows charging without any host write
    pins.strap <= 1'b1;
    cw(4);
    chk(16'(chg_ok), 16'h1);
    close_out();
  end
endmodule // tb_top
